// ### rtl/ldc_dim_if.sv
`timescale 1ns/1ps
`default_nettype none
// dimming level in, edge and pulse-width mode back
interface ldc_dim_if;
  logic dim;
  logic dim_rise;
  logic short_mode;
  modport src (input dim, output dim_rise, output short_mode);
  modport snk (output dim, input dim_rise, input short_mode);
endinterface
`default_nettype wire

// ### rtl/ldc_dim_mode.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_dim_mode
  import ldc_pkg::*;
#(
  parameter int CNT_W = 4
)
(
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // dimming group
  ldc_dim_if.src    dif
);
  initial
  begin
    if (LDC_LONG_CYC >= (1 << CNT_W))
      $error("ldc_dim_mode: CNT_W too small");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             dim_ff;
  logic             rise_ff;
  logic             nxt_rise;
  logic             mode_ff;
  logic             nxt_mode;

  ////////////////////////////////////////////////////////////////
  // count on-pulse cycles; decide mode at the falling edge.
  // a pulse of exactly the short bound keeps the previous mode,
  // which gives a one-cycle hysteresis band against dither
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_mode = mode_ff;
    nxt_rise = dif.dim & ~dim_ff;
    if (dif.dim)
    begin
      if (!dim_ff)
        nxt_cnt = CNT_W'(1);
      else if (cnt_ff != {CNT_W{1'b1}})
        nxt_cnt = cnt_ff + CNT_W'(1);  // saturates
    end
    else if (dim_ff)
    begin
      if (cnt_ff < CNT_W'(LDC_SHORT_CYC))
        nxt_mode = 1'b1;
      else if (cnt_ff >= CNT_W'(LDC_LONG_CYC))
        nxt_mode = 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cnt_ff  <= '0;
      dim_ff  <= 1'b0;
      rise_ff <= 1'b0;
      mode_ff <= LDC_MODE_RST;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      dim_ff  <= dif.dim;
      rise_ff <= nxt_rise;
      mode_ff <= nxt_mode;
    end
  end

  assign dif.dim_rise   = rise_ff;
  assign dif.short_mode = mode_ff;

  ////////////////////////////////////////////////////////////////
  short_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    dim_ff && !dif.dim && cnt_ff < CNT_W'(LDC_SHORT_CYC) |=> mode_ff)
    else $error("short pulse did not select overvoltage feedback");
  long_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    dim_ff && !dif.dim && cnt_ff >= CNT_W'(LDC_LONG_CYC) |=> !mode_ff)
    else $error("long pulse did not select sink feedback");
endmodule
`default_nettype wire

// ### rtl/ldc_pkg.sv
package ldc_pkg;
  // channel count and oscillator rate (40 MHz, 25 ns)
  localparam int LDC_CH      = 4;
  localparam int LDC_CLK_KHZ = 40_000;
  // soft-start time in ms and its cycle count
  localparam int LDC_SOFT_MS  = 100;
  localparam int LDC_SOFT_CYC = LDC_SOFT_MS * LDC_CLK_KHZ;
  // cycles spent sampling for unused channels at power-up
  localparam int LDC_DETECT_CYC = 16;
  // on-pulse bounds in oscillator cycles for feedback choice
  localparam int LDC_SHORT_CYC = 5;
  localparam int LDC_LONG_CYC  = 6;
  // reset values
  localparam logic [3:0] LDC_MASK_RST = 4'h0;
  localparam logic       LDC_MODE_RST = 1'b0;
  // sequencer states
  typedef enum logic [1:0]
  {
    ST_OFF    = 2'b00,
    ST_DETECT = 2'b01,
    ST_SOFT   = 2'b10,
    ST_RUN    = 2'b11
  } ldc_state_e;
endpackage

// ### rtl/ldc_sequencer.sv
// How it works
// - dimming high enables sinks, low disables them
// - dimming low stops switching, detaches amplifier, unless on overvoltage feedback
// - on-pulse under 5 cycles selects overvoltage feedback
// - on-pulse of 6+ cycles selects sink feedback
// - short-pulse mode keeps amplifier attached and switching
// - normal feedback is lowest active sink versus 1V
// - start only when both supply monitors are good
// - enable low shuts everything down
// - detect unused channels before soft-start
// - soft-start on overvoltage feedback, ends at 1V/95%
// - soft-start lasts typically 100 ms
// - 1V sink check only while dimming high
// - after overvoltage, adaptive control at next on-pulse
// - overvoltage stops switching, gate drive low
// - sinks below 300mV leave the minimum detector
// - unused channels never raise the fault flag
// - fault on open, short or overtemperature
// - short and thermal faults self-release
// - open fault latches until enable toggles or a supply drops
// - overtemperature stops converter until it cools
// - short check on each dimming rising edge after detection
// - short threshold strapped high disables shorts
`timescale 1ns/1ps
`default_nettype none
module ldc_sequencer
  import ldc_pkg::*;
#(
  parameter int SOFT_CYC = LDC_SOFT_CYC
)
(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  // power and enable
  input  wire logic              enable_in,
  input  wire logic              uv_in_ok_in,
  input  wire logic              uv_vcc_ok_in,
  // host dimming
  input  wire logic              dimming_input_in,
  // analog comparator results
  input  wire logic [LDC_CH-1:0] sink_at_return_in,
  input  wire logic [LDC_CH-1:0] sink_below_300_in,
  input  wire logic [LDC_CH-1:0] short_det_in,
  input  wire logic              min_sink_at_1v_in,
  input  wire logic              ovp_reached_in,
  input  wire logic              ovp_95_in,
  input  wire logic              overtemp_in,
  input  wire logic              short_threshold_input_in,
  // converter and channel control
  output logic [LDC_CH-1:0]      sink_enable_out,
  output logic [LDC_CH-1:0]      detector_include_out,
  output logic                   gate_drive_out,
  output logic                   ea_attach_out,
  output logic                   fb_sel_ovp_out,
  // open-drain fault pin
  output logic                   fault_flag_n_out,
  output logic                   fault_flag_oe_out
);
  localparam int TMR_W = $clog2(SOFT_CYC + 1);

  initial
  begin
    if (SOFT_CYC <= LDC_DETECT_CYC)
      $error("ldc_sequencer: SOFT_CYC too small");
  end

  ldc_dim_if dif ();

  assign dif.dim = dimming_input_in;

  ldc_dim_mode ldc_dim_mode_inst
  (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .dif     (dif)
  );

  ////////////////////////////////////////////////////////////////
  // power sequencing
  ldc_state_e       state_ff;
  ldc_state_e       nxt_state;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] nxt_tmr;
  logic             pwr_ok;
  logic             soft_done;

  assign pwr_ok = enable_in & uv_in_ok_in & uv_vcc_ok_in;
  // sink 1V only counts while strings are lit
  assign soft_done = (dimming_input_in & min_sink_at_1v_in)
                   | ovp_95_in
                   | (tmr_ff == TMR_W'(SOFT_CYC - 1));

  // next state and timer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_tmr   = tmr_ff + TMR_W'(1);
    if (!pwr_ok)
    begin
      nxt_state = ST_OFF;
      nxt_tmr   = '0;
    end
    else
    begin
      unique case (state_ff)
        ST_OFF:
        begin
          nxt_state = ST_DETECT;
          nxt_tmr   = '0;
        end
        ST_DETECT:
        begin
          if (tmr_ff == TMR_W'(LDC_DETECT_CYC - 1))
          begin
            nxt_state = ST_SOFT;
            nxt_tmr   = '0;
          end
        end
        ST_SOFT:
        begin
          if (soft_done)
            nxt_state = ST_RUN;
        end
        ST_RUN:
          nxt_tmr = tmr_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_OFF;
      tmr_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
    end
  end

  ////////////////////////////////////////////////////////////////
  // channel flags: unused, open, shorted, plus latches
  logic [LDC_CH-1:0] unused_ff;
  logic [LDC_CH-1:0] nxt_unused;
  logic [LDC_CH-1:0] open_ff;
  logic [LDC_CH-1:0] nxt_open;
  logic [LDC_CH-1:0] short_ff;
  logic [LDC_CH-1:0] nxt_short;
  logic              ovp_latch_ff;
  logic              nxt_ovp_latch;
  logic              ovp_hold_ff;
  logic              nxt_ovp_hold;
  logic              run;
  logic              ovp_evt;

  assign run     = (state_ff == ST_SOFT) | (state_ff == ST_RUN);
  assign ovp_evt = run & ovp_reached_in;

  // everything clears in the off state, so an enable toggle
  // or a supply drop is what releases the open latch
  always_comb
  begin
    nxt_unused    = unused_ff;
    nxt_open      = open_ff;
    nxt_short     = short_ff;
    nxt_ovp_latch = ovp_latch_ff;
    nxt_ovp_hold  = ovp_hold_ff;
    if (state_ff == ST_OFF)
    begin
      nxt_unused    = LDC_MASK_RST;
      nxt_open      = LDC_MASK_RST;
      nxt_short     = LDC_MASK_RST;
      nxt_ovp_latch = 1'b0;
      nxt_ovp_hold  = 1'b0;
    end
    else
    begin
      if (state_ff == ST_DETECT)
        nxt_unused = unused_ff | sink_at_return_in;
      if (ovp_evt)
      begin
        nxt_open      = open_ff | (sink_below_300_in & ~unused_ff);
        nxt_ovp_latch = 1'b1;
      end
      // a fresh overvoltage outranks the edge that would release
      if (ovp_evt)
        nxt_ovp_hold = 1'b1;
      else if (dif.dim_rise)
        nxt_ovp_hold = 1'b0;
      // shorts are judged only once detection is over; an earlier
      // edge could flag a channel that is later found unused
      if (short_threshold_input_in)
        nxt_short = LDC_MASK_RST;
      else if (dif.dim_rise && run)
        nxt_short = short_det_in & ~unused_ff & ~open_ff;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      unused_ff    <= LDC_MASK_RST;
      open_ff      <= LDC_MASK_RST;
      short_ff     <= LDC_MASK_RST;
      ovp_latch_ff <= 1'b0;
      ovp_hold_ff  <= 1'b0;
    end
    else
    begin
      unused_ff    <= nxt_unused;
      open_ff      <= nxt_open;
      short_ff     <= nxt_short;
      ovp_latch_ff <= nxt_ovp_latch;
      ovp_hold_ff  <= nxt_ovp_hold;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered outputs
  logic [LDC_CH-1:0] sink_en_ff;
  logic [LDC_CH-1:0] nxt_sink_en;
  logic [LDC_CH-1:0] incl_ff;
  logic [LDC_CH-1:0] nxt_incl;
  logic              sw_ff;
  logic              nxt_sw;
  logic              fb_ovp_ff;
  logic              nxt_fb_ovp;
  logic              fault_ff;
  logic              nxt_fault;

  always_comb
  begin
    // soft-start, short pulses and the post-overvoltage clamp
    // all regulate on the overvoltage sense
    nxt_fb_ovp = (state_ff == ST_SOFT) | dif.short_mode | ovp_hold_ff;
    nxt_incl   = ~unused_ff & ~open_ff & ~short_ff;
    nxt_sink_en = {LDC_CH{dimming_input_in & run}} & nxt_incl;
    // converter idles in the dark unless on overvoltage sense
    nxt_sw = run & ~overtemp_in
           & (dimming_input_in | nxt_fb_ovp);
    nxt_fault = ovp_latch_ff | (|short_ff) | overtemp_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sink_en_ff <= LDC_MASK_RST;
      incl_ff    <= LDC_MASK_RST;
      sw_ff      <= 1'b0;
      fb_ovp_ff  <= 1'b0;
      fault_ff   <= 1'b0;
    end
    else
    begin
      sink_en_ff <= nxt_sink_en;
      incl_ff    <= nxt_incl;
      sw_ff      <= nxt_sw;
      fb_ovp_ff  <= nxt_fb_ovp;
      fault_ff   <= nxt_fault;
    end
  end

  assign sink_enable_out      = sink_en_ff;
  assign detector_include_out = incl_ff;
  assign ea_attach_out        = sw_ff;
  assign fb_sel_ovp_out       = fb_ovp_ff;
  // comparators cut the gate at once, not a cycle later
  assign gate_drive_out = sw_ff & ~ovp_reached_in & ~overtemp_in;
  assign fault_flag_n_out  = 1'b0;  // pulls low only when enabled
  assign fault_flag_oe_out = fault_ff;

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  dim_off_a: assert property (!dimming_input_in |=> sink_enable_out == 4'h0)
    else $error("sinks on while dimming low");
  dark_idle_a: assert property (
    !dimming_input_in && state_ff == ST_RUN && !dif.short_mode && !ovp_hold_ff
    |=> !ea_attach_out)
    else $error("converter active during dimming low");
  short_fb_a: assert property (
    state_ff == ST_RUN && dif.short_mode && !overtemp_in && pwr_ok
    |=> fb_sel_ovp_out && ea_attach_out)
    else $error("short pulse mode not on overvoltage feedback");
  supply_gate_a: assert property (
    !uv_in_ok_in || !uv_vcc_ok_in |=> ##1 sink_enable_out == 4'h0 && !ea_attach_out)
    else $error("active with a supply below threshold");
  enable_off_a: assert property (!enable_in |=> state_ff == ST_OFF)
    else $error("enable low did not shut down");
  detect_first_a: assert property (
    state_ff == ST_SOFT && $past(state_ff) != ST_SOFT |-> $past(state_ff) == ST_DETECT)
    else $error("soft-start entered without detection");
  soft_end_a: assert property (state_ff == ST_SOFT && ovp_95_in && pwr_ok
    |=> state_ff == ST_RUN)
    else $error("soft-start did not end at 95 percent");
  ovp_gate_a: assert property (ovp_reached_in |-> !gate_drive_out)
    else $error("gate drive active at overvoltage");
  ovp_drop_a: assert property (ovp_evt && pwr_ok
    |=> ##1 (detector_include_out & $past(sink_below_300_in, 2) & ~unused_ff) == 4'h0)
    else $error("low sink still in minimum detector");
  unused_quiet_a: assert property ((short_ff & unused_ff) == 4'h0)
    else $error("unused channel flagged shorted");
  open_latch_a: assert property (ovp_evt && pwr_ok ##1 pwr_ok |=> fault_flag_oe_out)
    else $error("overvoltage did not latch fault");
  thermal_a: assert property (overtemp_in |=> !ea_attach_out ##0 fault_flag_oe_out)
    else $error("overtemperature did not stop converter");
  short_off_a: assert property (short_threshold_input_in |=> short_ff == 4'h0)
    else $error("short detection active while strapped off");
  // per-cycle checks on masks, latches and feedback hand-over
  unused_catch_a: assert property (state_ff == ST_DETECT
    |=> (unused_ff & $past(sink_at_return_in)) == $past(sink_at_return_in))
    else $error("channel tied to return not marked unused");
  sink_follow_a: assert property (dimming_input_in && run
    |=> sink_enable_out == detector_include_out)
    else $error("lit sinks differ from active channels");
  soft_lit_a: assert property (
    state_ff == ST_SOFT && dimming_input_in && min_sink_at_1v_in && pwr_ok |=> state_ff == ST_RUN)
    else $error("soft-start did not end at sink level");
  hold_release_a: assert property (ovp_hold_ff && dif.dim_rise && !ovp_evt
    |=> !ovp_hold_ff)
    else $error("overvoltage hold not released at on-pulse");
  short_catch_a: assert property (dif.dim_rise && run && !short_threshold_input_in
    |=> short_ff == $past(short_det_in & ~unused_ff & ~open_ff))
    else $error("short mask not taken at dimming edge");
  fault_release_a: assert property (short_ff == 4'h0 && !overtemp_in && !ovp_latch_ff
    |=> !fault_flag_oe_out)
    else $error("fault flag stuck after fault gone");
  open_hold_a: assert property (ovp_latch_ff && state_ff != ST_OFF
    |=> ovp_latch_ff)
    else $error("open fault latch released while enabled");
  hot_gate_a: assert property (overtemp_in |-> !gate_drive_out)
    else $error("gate drive active while hot");
endmodule
`default_nettype wire

// ### tb/ldc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ldc_host_model
(
  // clock
  input  wire logic mclk_in,
  // host pins
  output var logic  enable_out,
  output var logic  dimming_out
);
  // host starts quiet so the device sees a clean off state
  initial
  begin
    enable_out  = 1'b0;
    dimming_out = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // levels change 2 ns after an edge, never on it, to avoid sampling races
  task automatic set_en(input logic v);
  begin
    @(posedge mclk_in);
    #2 enable_out = v;
  end
  endtask
  // plain dimming level change
  task automatic set_dim(input logic v);
  begin
    @(posedge mclk_in);
    #2 dimming_out = v;
  end
  endtask
  // on-pulse seen high at exactly w rising edges, then low
  task automatic pulse(input int w);
  begin
    set_dim(1'b1);
    repeat (w) @(posedge mclk_in);
    #2 dimming_out = 1'b0;
  end
  endtask
endmodule
`default_nettype wire

// ### tb/led_driver_dim_fault_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module led_driver_dim_fault_sequencer_bench;
  import ldc_pkg::*;
  // one row: pulse width, short inputs, strap, and expected modes and fault
  typedef struct {int w; logic [3:0] sd; logic st; logic fb; logic ea; logic oe;} ldc_row_s;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic        enable_in;
  logic        uv_in_ok_in;
  logic        uv_vcc_ok_in;
  logic        dimming_input_in;
  logic [3:0]  sink_at_return_in;
  logic [3:0]  sink_below_300_in;
  logic [3:0]  short_det_in;
  logic        min_sink_at_1v_in;
  logic        ovp_reached_in;
  logic        ovp_95_in;
  logic        overtemp_in;
  logic        short_threshold_input_in;
  logic [3:0]  sink_enable_out;
  logic [3:0]  detector_include_out;
  logic        gate_drive_out;
  logic        ea_attach_out;
  logic        fb_sel_ovp_out;
  logic        fault_flag_n_out;
  logic        fault_flag_oe_out;
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;
  // ch3 is strapped unused at detect, so it must never fault
  ldc_row_s    rows [6] = '{'{3, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0},
                            '{8, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1},
                            '{4, 4'h0, 1'b0, 1'b1, 1'b1, 1'b0},
                            '{5, 4'h1, 1'b1, 1'b1, 1'b1, 1'b0},
                            '{6, 4'h8, 1'b0, 1'b0, 1'b0, 1'b0},
                            '{5, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0}};
  //////////////////////////////////////////////////////////////////////////////
  // 40 mhz oscillator
  always #12.5 mclk_in = ~mclk_in;
  // short soft-start timer keeps the run brief; must stay above the detect window
  ldc_sequencer #(.SOFT_CYC(64)) ldc_sequencer_inst
  (
    .mclk_in, .rst_in, .enable_in, .uv_in_ok_in, .uv_vcc_ok_in, .dimming_input_in,
    .sink_at_return_in, .sink_below_300_in, .short_det_in, .min_sink_at_1v_in,
    .ovp_reached_in, .ovp_95_in, .overtemp_in, .short_threshold_input_in,
    .sink_enable_out, .detector_include_out, .gate_drive_out, .ea_attach_out,
    .fb_sel_ovp_out, .fault_flag_n_out, .fault_flag_oe_out
  );
  ldc_host_model ldc_host_model_inst
  (
    .mclk_in     (mclk_in),
    .enable_out  (enable_in),
    .dimming_out (dimming_input_in)
  );
  //////////////////////////////////////////////////////////////////////////////
  // compare and count; four-state so an unknown never matches
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // advance k edges and land 2 ns after the last one
  task automatic step(input int k);
  begin
    repeat (k) @(posedge mclk_in);
    #2;
  end
  endtask
  // verdict and end of run
  task automatic close_out();
  begin
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    uv_in_ok_in = 1'b1;
    uv_vcc_ok_in = 1'b0;
    sink_at_return_in = 4'h8;
    sink_below_300_in = 4'h0;
    short_det_in = 4'h0;
    min_sink_at_1v_in = 1'b0;
    ovp_reached_in = 1'b0;
    ovp_95_in = 1'b0;
    overtemp_in = 1'b0;
    short_threshold_input_in = 1'b0;
    step(4);
    rst_in = 1'b0;
    chk("oe_reset", fault_flag_oe_out, 1'b0);
    chk("gate_reset", gate_drive_out, 1'b0);
    chk("flag_level", fault_flag_n_out, 1'b0);
    // regulator monitor still low: nothing may start
    ldc_host_model_inst.set_en(1'b1);
    ldc_host_model_inst.set_dim(1'b1);
    step(24);
    chk("sink_en_uv", sink_enable_out, 4'h0);
    chk("fb_uv", fb_sel_ovp_out, 1'b0);
    uv_vcc_ok_in = 1'b1;
    ldc_host_model_inst.set_dim(1'b0);
    // detect window must pass before soft-start shows
    n = 0;
    while (fb_sel_ovp_out !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    if (n >= 40)
    begin
      mismatches++;
      close_out();
    end
    chk("detect_first", 4'(n >= 16), 4'h1);
    chk("fb_soft", fb_sel_ovp_out, 1'b1);
    sink_at_return_in = 4'h0;
    ovp_95_in = 1'b1;
    step(1);
    ovp_95_in = 1'b0;
    step(3);
    chk("fb_run", fb_sel_ovp_out, 1'b0);
    // width table: feedback choice, amplifier hold, short faults
    foreach (rows[i])
    begin
      short_det_in = rows[i].sd;
      short_threshold_input_in = rows[i].st;
      ldc_host_model_inst.pulse(rows[i].w);
      step(4);
      chk("fb_sel", fb_sel_ovp_out, rows[i].fb);
      chk("ea_low", ea_attach_out, rows[i].ea);
      chk("gate_low", gate_drive_out, rows[i].ea);
      chk("short_oe", fault_flag_oe_out, rows[i].oe);
    end
    short_det_in = 4'h0;
    short_threshold_input_in = 1'b0;
    // sinks follow dimming
    ldc_host_model_inst.set_dim(1'b1);
    step(2);
    chk("sink_on", sink_enable_out, 4'h7);
    chk("gate_on", gate_drive_out, 1'b1);
    // overtemperature stops switching at once, fault follows and self-clears
    overtemp_in = 1'b1;
    #1 chk("gate_hot", gate_drive_out, 1'b0);
    step(2);
    chk("oe_hot", fault_flag_oe_out, 1'b1);
    overtemp_in = 1'b0;
    step(2);
    chk("oe_cool", fault_flag_oe_out, 1'b0);
    chk("gate_cool", gate_drive_out, 1'b1);
    // overvoltage with channel 1 open
    sink_below_300_in = 4'h2;
    ovp_reached_in = 1'b1;
    #1 chk("gate_ovp", gate_drive_out, 1'b0);
    step(3);
    chk("oe_open", fault_flag_oe_out, 1'b1);
    chk("incl_open", detector_include_out, 4'h5);
    chk("fb_hold", fb_sel_ovp_out, 1'b1);
    ovp_reached_in = 1'b0;
    sink_below_300_in = 4'h0;
    ldc_host_model_inst.set_dim(1'b0);
    step(3);
    chk("sink_off", sink_enable_out, 4'h0);
    chk("oe_latch", fault_flag_oe_out, 1'b1);
    ldc_host_model_inst.pulse(8);
    step(2);
    chk("fb_adapt", fb_sel_ovp_out, 1'b0);
    // an enable toggle, like a supply drop, releases the open latch
    ldc_host_model_inst.set_en(1'b0);
    step(3);
    chk("oe_en", fault_flag_oe_out, 1'b0);
    chk("gate_en", gate_drive_out, 1'b0);
    // second power-up: the 1V sink level ends soft-start only while lit
    min_sink_at_1v_in = 1'b1;
    ldc_host_model_inst.set_en(1'b1);
    step(24);
    chk("fb_dark_soft", fb_sel_ovp_out, 1'b1);
    ldc_host_model_inst.set_dim(1'b1);
    step(3);
    chk("fb_lit_run", fb_sel_ovp_out, 1'b0);
    // input supply drop shuts down like enable
    uv_in_ok_in = 1'b0;
    step(3);
    chk("sink_uv_in", sink_enable_out, 4'h0);
    // restart with no sink level: only the 16 + 64 cycle timers end soft-start
    uv_in_ok_in = 1'b1;
    min_sink_at_1v_in = 1'b0;
    step(76);
    chk("fb_timer_on", fb_sel_ovp_out, 1'b1);
    step(8);
    chk("fb_timer_off", fb_sel_ovp_out, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
